/* File: design/slot_pkg.sv */
package slot_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    // Acknowledge low pulse length in ns and in cycles
    localparam int unsigned ACK_PULSE_NS    = 200;
    localparam int unsigned ACK_PULSE_CYC   =
        (ACK_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Multiplexer relay travel time in ns and in cycles
    localparam int unsigned RELAY_NS        = 1000;
    localparam int unsigned RELAY_CYC       =
        (RELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SLOT_NUM        = 0;
    localparam int unsigned REG_COUNT       = 32;
    localparam logic [15:0] DATA_RESET      = 16'h0000;
    localparam logic [7:0]  TIMER_RESET     = 8'h00;

    typedef struct packed {
        logic       slot_sel_n;
        logic       bus_direction;
        logic [4:0] reg_select_lines;
        logic       poll_request_n;
        logic       bus_trigger_n;
        logic       opening_n;
    } bus_in_t;

    typedef enum logic [3:0] {
        CYC_IDLE = 4'b0001,
        CYC_ACK  = 4'b0010,
        CYC_HOLD = 4'b0100,
        CYC_WAIT = 4'b1000
    } cyc_state_t;

    typedef enum logic [3:0] {
        MUX_IDLE  = 4'b0001,
        MUX_OPEN  = 4'b0010,
        MUX_WAIT  = 4'b0100,
        MUX_CLOSE = 4'b1000
    } mux_state_t;
endpackage

/* File: design/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    // Pins and filtered levels
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge core_clk_i) begin
                if (reset_i) begin
                    level_o[g] <= 1'b1;
                end else if (s2_reg[g] == s3_reg[g]) begin
                    level_o[g] <= s3_reg[g];
                end
            end
        end
    endgenerate
endmodule // pin_sync

/* File: design/plugin_slot.sv */
`timescale 1ns/1ps
// Overview of operation
// RL1: Backplane reset held low keeps the accessory in reset.
// RL2: Direction high means controller reads, low means controller writes.
// RL3: Bus cycles are served only while slot select is low.
// RL4: Each bus cycle is acknowledged by a short low acknowledge pulse.
// RL5: Five active-high address lines choose one of 32 registers.
// RL6: Sixteen data lines: controller drives on writes, accessory on reads.
// RL7: Poll line low starts a parallel poll, answered by interrupting cards.
// RL8: During poll, reply low if service is wanted, else high.
// RL9: Controller sees each slot's reply on data bit equal to slot number.
// RL10: Trigger line low starts a trigger action in capable accessories.
// RL11: General interrupt output low requests general service.
// RL12: Normal-speed scan interrupt output driven low to interrupt.
// RL13: Fast scan interrupt output driven low to interrupt.
// RL14: Opening line driven low while opening; no close until line is high.
// RL15: Closing line driven low while a channel closes.
// RL16: Spare lines are neither driven nor read.
// RL17: Data drivers enabled only when selected and direction requests read.
module plugin_slot
    import slot_pkg::*;
(
    // Card clock and local reset
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    // Backplane control inputs
    input  wire logic         backplane_reset_n_i,
    input  wire logic         slot_sel_n_i,
    input  wire logic         bus_direction_i,
    input  wire logic [4:0]   reg_select_lines_i,
    input  wire logic         poll_request_n_i,
    input  wire logic         bus_trigger_n_i,
    // Backplane data lines
    input  wire logic [15:0]  backplane_data_lines_i,
    output logic      [15:0]  backplane_data_lines_o,
    output logic      [15:0]  backplane_data_lines_oe_o,
    // Handshake and poll
    output logic              transfer_ack_n_o,
    output logic              poll_reply_n_o,
    // Interrupts to the controller
    output logic              general_irq_n_o,
    output logic              slow_scan_irq_n_o,
    output logic              fast_scan_irq_n_o,
    // Multiplexer break-before-make lines
    input  wire logic         opening_n_i,
    output logic              opening_n_o,
    output logic              opening_n_oe_o,
    output logic              closing_n_o,
    // Card-side logic
    input  wire logic         service_req_i,
    input  wire logic         slow_scan_req_i,
    input  wire logic         fast_scan_req_i,
    input  wire logic         channel_close_req_i,
    output logic              trigger_pulse_o,
    output logic              card_reset_o
);
    import slot_pkg::*;

    logic [10:0]  sync_lvl;
    logic         brst_n;
    bus_in_t      bus;
    logic         rst;
    logic [15:0]  regs [REG_COUNT];
    logic [15:0]  wdata_lvl;
    cyc_state_t   cyc_reg;
    mux_state_t   mux_reg;
    logic [7:0]   ack_cnt_reg;
    logic [7:0]   mux_cnt_reg;
    logic         trig_prev_reg;
    logic         read_en;

    // Spare lines have no port at all [RL16]
    pin_sync #(.WIDTH(11)) u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pin_i      ({backplane_reset_n_i, slot_sel_n_i, bus_direction_i,
                      reg_select_lines_i, poll_request_n_i,
                      bus_trigger_n_i, opening_n_i}),
        .level_o    (sync_lvl)
    );

    assign brst_n = sync_lvl[10];
    assign bus    = sync_lvl[9:0];
    assign rst    = reset_i | ~brst_n; // [RL1]

    // Write data settles with the select, one cycle before the ack state
    pin_sync #(.WIDTH(16)) u_data_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pin_i      (backplane_data_lines_i), // [RL6]
        .level_o    (wdata_lvl)
    );

    // Cycle handshake
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            cyc_reg     <= CYC_IDLE;
            ack_cnt_reg <= TIMER_RESET;
        end else begin
            case (cyc_reg)
                CYC_IDLE: begin
                    if (!bus.slot_sel_n && bus.poll_request_n) begin // [RL3]
                        cyc_reg <= CYC_ACK;
                    end
                end
                CYC_ACK: begin
                    cyc_reg     <= CYC_HOLD;
                    ack_cnt_reg <= 8'(ACK_PULSE_CYC - 1);
                end
                CYC_HOLD: begin
                    if (ack_cnt_reg == TIMER_RESET) begin
                        cyc_reg <= CYC_WAIT;
                    end else begin
                        ack_cnt_reg <= ack_cnt_reg - 8'h01;
                    end
                end
                CYC_WAIT: begin
                    // One ack per select; wait for deselect
                    if (bus.slot_sel_n) begin
                        cyc_reg <= CYC_IDLE;
                    end
                end
                default: cyc_reg <= CYC_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            transfer_ack_n_o <= 1'b1;
        end else begin
            transfer_ack_n_o <= ~(cyc_reg == CYC_ACK ||
                                  (cyc_reg == CYC_HOLD &&
                                   ack_cnt_reg != TIMER_RESET)); // [RL4]
        end
    end

    // Register file write
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= DATA_RESET;
            end
        end else if (cyc_reg == CYC_ACK && !bus.bus_direction) begin // [RL2]
            regs[bus.reg_select_lines] <= wdata_lvl; // [RL5]
        end
    end

    assign read_en = !bus.slot_sel_n && bus.bus_direction &&
                     bus.poll_request_n;

    // Read drive; released whenever not a selected read
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            backplane_data_lines_o    <= DATA_RESET;
            backplane_data_lines_oe_o <= 16'h0000;
        end else begin
            backplane_data_lines_o    <= regs[bus.reg_select_lines]; // [RL5]
            backplane_data_lines_oe_o <= {16{read_en}}; // [RL17] [RL6]
        end
    end

    // Poll reply; backplane wiring routes it to the slot's data bit [RL9]
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            poll_reply_n_o <= 1'b1;
        end else begin
            poll_reply_n_o <= ~(!bus.poll_request_n &&
                                service_req_i); // [RL7] [RL8]
        end
    end

    // Interrupt outputs
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            general_irq_n_o   <= 1'b1;
            slow_scan_irq_n_o <= 1'b1;
            fast_scan_irq_n_o <= 1'b1;
        end else begin
            general_irq_n_o   <= ~service_req_i;   // [RL11]
            slow_scan_irq_n_o <= ~slow_scan_req_i; // [RL12]
            fast_scan_irq_n_o <= ~fast_scan_req_i; // [RL13]
        end
    end

    // Trigger: one pulse on each falling edge of the filtered line
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            trig_prev_reg   <= 1'b1;
            trigger_pulse_o <= 1'b0;
        end else begin
            trig_prev_reg   <= bus.bus_trigger_n;
            trigger_pulse_o <= trig_prev_reg & ~bus.bus_trigger_n; // [RL10]
        end
    end

    always_ff @(posedge core_clk_i) begin
        card_reset_o <= rst; // [RL1]
    end

    // Break-before-make sequencer
    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            mux_reg     <= MUX_IDLE;
            mux_cnt_reg <= TIMER_RESET;
        end else begin
            case (mux_reg)
                MUX_IDLE: begin
                    if (channel_close_req_i) begin
                        mux_reg     <= MUX_OPEN;
                        mux_cnt_reg <= 8'(RELAY_CYC - 1);
                    end
                end
                MUX_OPEN: begin
                    if (mux_cnt_reg == TIMER_RESET) begin
                        mux_reg <= MUX_WAIT;
                    end else begin
                        mux_cnt_reg <= mux_cnt_reg - 8'h01;
                    end
                end
                MUX_WAIT: begin
                    // Own drive already released; wait for others [RL14]
                    if (bus.opening_n) begin
                        mux_reg     <= MUX_CLOSE;
                        mux_cnt_reg <= 8'(RELAY_CYC - 1);
                    end
                end
                MUX_CLOSE: begin
                    if (mux_cnt_reg == TIMER_RESET) begin
                        mux_reg <= MUX_IDLE;
                    end else begin
                        mux_cnt_reg <= mux_cnt_reg - 8'h01;
                    end
                end
                default: mux_reg <= MUX_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst) begin
            opening_n_o    <= 1'b1;
            opening_n_oe_o <= 1'b0;
            closing_n_o    <= 1'b1;
        end else begin
            opening_n_o    <= 1'b0;
            opening_n_oe_o <= (mux_reg == MUX_OPEN) &&
                              (mux_cnt_reg != TIMER_RESET); // [RL14]
            closing_n_o    <= ~(mux_reg == MUX_CLOSE); // [RL15]
        end
    end
endmodule // plugin_slot

/* File: bench/plugin_slot_sva.sv */
`timescale 1ns/1ps
module plugin_slot_sva (
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire logic        slot_sel_n_i,
    input wire logic        bus_direction_i,
    input wire logic        poll_request_n_i,
    input wire logic        bus_trigger_n_i,
    input wire logic        opening_n_i,
    input wire logic        service_req_i,
    input wire logic        slow_scan_req_i,
    input wire logic        fast_scan_req_i,
    input wire logic [15:0] backplane_data_lines_oe_o,
    input wire logic        transfer_ack_n_o,
    input wire logic        poll_reply_n_o,
    input wire logic        general_irq_n_o,
    input wire logic        slow_scan_irq_n_o,
    input wire logic        fast_scan_irq_n_o,
    input wire logic        opening_n_o,
    input wire logic        opening_n_oe_o,
    input wire logic        closing_n_o,
    input wire logic        trigger_pulse_o,
    input wire logic        card_reset_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    property p_sel; !transfer_ack_n_o |-> !$past(slot_sel_n_i); endproperty
    a_sel: assert property (p_sel) else $error("ack unselected");
    property p_ack; $fell(transfer_ack_n_o) |=> !transfer_ack_n_o ##1
        transfer_ack_n_o; endproperty
    a_ack: assert property (p_ack) else $error("ack pulse length");
    property p_oe; $rose(backplane_data_lines_oe_o[0]) |->
        $past(!slot_sel_n_i && bus_direction_i, 3); endproperty
    a_oe: assert property (p_oe) else $error("drive not read");
    property p_poll; $fell(poll_reply_n_o) |->
        $past(!poll_request_n_i, 3) && $past(service_req_i); endproperty
    a_poll: assert property (p_poll) else $error("poll reply");
    property p_irq; {general_irq_n_o, slow_scan_irq_n_o, fast_scan_irq_n_o}
        == ~$past({service_req_i, slow_scan_req_i, fast_scan_req_i});
    endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_trig; trigger_pulse_o |-> $past(!bus_trigger_n_i, 3) ##1
        !trigger_pulse_o; endproperty
    a_trig: assert property (p_trig) else $error("trigger pulse");
    property p_open; $rose(opening_n_oe_o) |-> !opening_n_o ##1
        opening_n_oe_o [*8] ##1 !opening_n_oe_o; endproperty
    a_open: assert property (p_open) else $error("opening drive");
    property p_close; $fell(closing_n_o) |->
        $past(opening_n_i, 3) && !opening_n_oe_o; endproperty
    a_close: assert property (p_close) else $error("early close");
    property p_rst; card_reset_o |-> transfer_ack_n_o &&
        backplane_data_lines_oe_o == 16'h0000; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    c_ack: cover property ($fell(transfer_ack_n_o));
    c_poll: cover property ($fell(poll_reply_n_o));
    c_close: cover property ($fell(closing_n_o));
endmodule // plugin_slot_sva
bind plugin_slot plugin_slot_sva u_sva (.*);

/* File: bench/ctrl_model.sv */
`timescale 1ns/1ps
module ctrl_model (
    input  wire logic        core_clk_i,
    input  wire logic        transfer_ack_n_i,
    input  wire logic [15:0] dut_data_i,
    input  wire logic [15:0] dut_oe_i,
    output logic             slot_sel_n_o,
    output logic             bus_direction_o,
    output logic [4:0]       reg_select_lines_o,
    output logic [15:0]      line_o
);
    logic [15:0] wdata;
    logic        drive;
    // Released lines show the inverse, so a stale value cannot pass
    assign line_o = (dut_oe_i & dut_data_i) |
        (~dut_oe_i & (drive ? wdata : ~wdata));
    initial begin
        {slot_sel_n_o, bus_direction_o, drive} = 3'b100;
        reg_select_lines_o = 5'h00;
        wdata = 16'h0000;
    end
    task automatic xfer(input logic rd, input logic [4:0] a,
        input logic [15:0] d, output logic [15:0] q, output logic ok);
        ok = 1'b0;
        q = 16'h0000;
        @(posedge core_clk_i);
        slot_sel_n_o <= 1'b0;
        bus_direction_o <= rd;
        reg_select_lines_o <= a;
        wdata <= d;
        drive <= !rd;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge core_clk_i);
            ok = !transfer_ack_n_i;
            q = line_o;
        end
        slot_sel_n_o <= 1'b1;
        drive <= 1'b0;
        repeat (8) @(posedge core_clk_i);
    endtask
endmodule // ctrl_model

/* File: bench/plugin_slot_tb.sv */
`timescale 1ns/1ps
module plugin_slot_tb;
    import slot_pkg::*;
    logic core_clk_i, reset_i, bp_rst_n, poll_n, trig_n, other_open_n;
    logic svc, slow_req, fast_req, close_req, sel_n, dir, ack_n, reply_n;
    logic g_n, s_n, f_n, open_o, open_oe, closing_n, trig_p, card_rst;
    logic [4:0]  addr;
    logic [15:0] dout, doe, line, q;
    logic        ok;
    int          err_count, checks_done, cyc, n;
    // Open-drain opening line with pull-up, shared with another card
    wire open_line = other_open_n && !(open_oe && !open_o);
    // Backplane wiring puts the reply on the data bit of this slot
    wire [15:0] poll_view = ~({15'h0000, !reply_n} << SLOT_NUM);
    ctrl_model m (.core_clk_i(core_clk_i), .transfer_ack_n_i(ack_n),
        .dut_data_i(dout), .dut_oe_i(doe), .slot_sel_n_o(sel_n),
        .bus_direction_o(dir), .reg_select_lines_o(addr), .line_o(line));
    plugin_slot DUT (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .backplane_reset_n_i(bp_rst_n), .slot_sel_n_i(sel_n),
        .bus_direction_i(dir), .reg_select_lines_i(addr),
        .poll_request_n_i(poll_n), .bus_trigger_n_i(trig_n),
        .backplane_data_lines_i(line), .backplane_data_lines_o(dout),
        .backplane_data_lines_oe_o(doe), .transfer_ack_n_o(ack_n),
        .poll_reply_n_o(reply_n), .general_irq_n_o(g_n),
        .slow_scan_irq_n_o(s_n), .fast_scan_irq_n_o(f_n),
        .opening_n_i(open_line), .opening_n_o(open_o),
        .opening_n_oe_o(open_oe), .closing_n_o(closing_n),
        .service_req_i(svc), .slow_scan_req_i(slow_req),
        .fast_scan_req_i(fast_req), .channel_close_req_i(close_req),
        .trigger_pulse_o(trig_p), .card_reset_o(card_rst));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic t_rw;
        for (int i = 0; i < 2; i++) begin
            m.xfer(1'b0, 5'(i * 31), 16'h5a3c << i, q, ok);
            check(16'(ok), 16'h0001);
        end
        for (int i = 0; i < 2; i++) begin
            m.xfer(1'b1, 5'(i * 31), 16'h0000, q, ok);
            check(q, 16'h5a3c << i);
            check(16'(ok), 16'h0001);
        end
    endtask
    task automatic t_poll;
        svc <= 1'b1;
        poll_n <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        check(16'(reply_n), 16'h0000);
        check(poll_view, ~(16'h0001 << SLOT_NUM));
        m.xfer(1'b1, 5'h00, 16'h0000, q, ok);
        check(16'(ok), 16'h0000);
        svc <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        check(16'(reply_n), 16'h0001);
        check(poll_view, 16'hffff);
        poll_n <= 1'b1;
    endtask
    task automatic t_irq;
        for (int i = 0; i < 8; i++) begin
            {svc, slow_req, fast_req} <= 3'(i);
            repeat (3) @(posedge core_clk_i);
            check(16'({g_n, s_n, f_n}), 16'(~i & 7));
        end
        {svc, slow_req, fast_req} <= 3'h0;
    endtask
    task automatic t_trig;
        n = 0;
        trig_n <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(posedge core_clk_i);
            n += int'(trig_p);
            if (i == 9) trig_n <= 1'b1;
        end
        check(16'(n), 16'h0001);
    endtask
    task automatic t_mux;
        other_open_n <= 1'b0;
        close_req <= 1'b1;
        @(posedge core_clk_i);
        close_req <= 1'b0;
        repeat (30) @(posedge core_clk_i);
        check(16'(closing_n), 16'h0001);
        other_open_n <= 1'b1;
        for (int i = 0; i < 20 && closing_n !== 1'b0; i++) begin
            @(posedge core_clk_i);
        end
        check(16'(closing_n), 16'h0000);
        // One low cycle already seen; the rest of the close phase follows
        n = 0;
        for (int i = 0; i < 15; i++) begin
            @(posedge core_clk_i);
            n += int'(!closing_n);
        end
        check(16'(n), 16'(RELAY_CYC - 1));
        check(16'(closing_n), 16'h0001);
    endtask
    task automatic t_bprst;
        bp_rst_n <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        check(16'(card_rst), 16'h0001);
        bp_rst_n <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        m.xfer(1'b1, 5'h1f, 16'h0000, q, ok);
        check(q, 16'h0000);
        check(16'(ok), 16'h0001);
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    // Whole run needs well under 2000 cycles
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        {reset_i, bp_rst_n, poll_n, trig_n, other_open_n} = 5'h1f;
        {svc, slow_req, fast_req, close_req} = 4'h0;
        {err_count, checks_done, cyc} = 0;
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        t_rw();
        t_poll();
        t_irq();
        t_trig();
        t_mux();
        t_bprst();
        end_sim();
    end
endmodule // plugin_slot_tb
